// [rtl/int_ctrl_regs.vh]
// register offsets, field positions, reset values and fixed codes
`ifndef INT_CTRL_REGS_VH
`define INT_CTRL_REGS_VH
`define VEC_LOW_ADDR 8'h33
`define CTRL_ADDR 8'h34
`define VEC_LOW_RESET 8'h00
`define CTRL_FLAG_BIT 7
`define CTRL_POS_BIT 6
`define CTRL_EN_RESET 3'h1
`define NMI_RESTART 16'h0066
`define MODE1_RESTART 16'h0038
`define TRAP_RESTART 16'h0000
`define NUM_SOURCES 12
`endif

// [rtl/int_priority_pick.v]
// fixed priority arbiter over the vectored maskable sources
`timescale 1ns/10ps
`default_nettype none
module int_priority_pick
(
   input wire [9:0] pending,
   output reg [3:0] index,
   output reg found
);
   integer i;
   always @*
   begin
      index = 4'h0;
      found = 1'b0;
      // lowest index wins, so scan from the top down and let the last hit stand
      for (i = 9; i >= 0; i = i - 1)
      begin
         if (pending[i])
         begin
            index = i[3:0];
            found = 1'b1;
         end
      end
   end
endmodule // int_priority_pick
`default_nettype wire

// [rtl/interrupt_trap_control.v]
// interrupt and trap control: vector low, control register, enable flags
`timescale 1ns/10ps
`default_nettype none
`include "int_ctrl_regs.vh"
module interrupt_trap_control
(
   input wire clk,
   input wire reset_n,
   // internal I/O access
   input wire [7:0] io_addr,
   input wire [7:0] io_wdata,
   input wire io_write,
   input wire io_read,
   output reg [7:0] io_rdata,
   // sequencer events
   input wire enable_interrupts_instr,
   input wire disable_interrupts_instr,
   input wire nonmaskable_return,
   input wire maskable_return,
   input wire load_a_from_i_or_r,
   input wire [7:0] vector_high,
   input wire [1:0] level0_mode,
   input wire undefined_fetch,
   input wire undefined_in_third_byte,
   input wire level0_ack_fetch,
   input wire ack_take,
   input wire fault_insert_state,
   // request inputs, active low as on the pins; internal_request is active high
   input wire nmi_n,
   input wire level0_request_n,
   input wire level1_request_n,
   input wire level2_request_n,
   input wire [7:0] internal_request,
   // answers to the sequencer
   output wire service_request,
   output reg [3:0] service_kind,
   output reg [15:0] service_address,
   output reg vector_from_bus,
   output wire vector_from_table,
   output reg parity_flag_value,
   output reg parity_flag_load,
   output wire cycle_insert_block,
   output wire primary_global_enable_out,
   output wire saved_global_enable_out
);
   // ==========================================================
   // kinds of service handed to the sequencer
   // ==========================================================
   localparam [3:0] kind_trap = 4'h1;
   localparam [3:0] kind_nmi = 4'h2;
   localparam [3:0] kind_level0 = 4'h4;
   localparam [3:0] kind_vector = 4'h8;

   // ==========================================================
   // trap sequence states, one-hot
   // ==========================================================
   localparam [1:0] trap_idle = 2'h1;
   localparam [1:0] trap_offered = 2'h2;

   // ==========================================================
   // state
   // ==========================================================
   reg [2:0] vector_low_base;
   reg fault_flag;
   reg fault_byte_position;
   reg level0_input_enable;
   reg level1_input_enable;
   reg level2_input_enable;
   reg primary_global_enable;
   reg saved_global_enable;
   reg nmi_prev;
   reg nmi_latched;
   reg [1:0] trap_state;
   reg [1:0] next_trap_state;
   wire [9:0] pending;
   wire [3:0] pick_index;
   wire pick_found;
   wire maskable_ok;
   wire trap_event;
   wire trap_pending;
   wire level0_ok;
   wire vec_low_write;
   wire ctrl_write;
   wire vec_low_read;
   wire ctrl_read;
   reg [3:0] next_service_kind;
   reg [15:0] next_service_address;
   reg next_vector_from_bus;
   reg [7:0] next_io_rdata;

   // fixed low codes: even steps of two, one per vectored source
   function [4:0] fixed_code;
      input [3:0] idx;
      begin
         fixed_code = {idx, 1'b0};
      end
   endfunction

   // one compare function, called separately for each write and read strobe
   function reg_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         reg_hit = (addr == target);
      end
   endfunction

   // a mode 2 acknowledge fetches a vector byte, which cannot trap
   assign trap_event = undefined_fetch &
      (~level0_ack_fetch | (level0_mode == 2'h0));

   assign vec_low_write = io_write & reg_hit(io_addr, `VEC_LOW_ADDR);
   assign ctrl_write = io_write & reg_hit(io_addr, `CTRL_ADDR);
   assign vec_low_read = io_read & reg_hit(io_addr, `VEC_LOW_ADDR);
   assign ctrl_read = io_read & reg_hit(io_addr, `CTRL_ADDR);

   // ==========================================================
   // trap sequence: offered until the sequencer takes it
   // ==========================================================
   always @*
   begin
      next_trap_state = trap_state;
      case (trap_state)
         trap_idle:
         begin
            if (trap_event)
               next_trap_state = trap_offered;
         end
         trap_offered:
         begin
            // a fresh fault in the taking cycle stays offered
            if (ack_take && service_kind == kind_trap && !trap_event)
               next_trap_state = trap_idle;
         end
         default:
            next_trap_state = trap_idle;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         trap_state <= trap_idle;
      else
         trap_state <= next_trap_state;
   end

   assign trap_pending = (trap_state == trap_offered);

   // ==========================================================
   // register writes and flag updates
   // ==========================================================
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         vector_low_base <= 3'h0;
         fault_flag <= 1'b0;
         fault_byte_position <= 1'b0;
         {level2_input_enable, level1_input_enable, level0_input_enable}
            <= `CTRL_EN_RESET;
         primary_global_enable <= 1'b0;
         saved_global_enable <= 1'b0;
         nmi_prev <= 1'b1;
         nmi_latched <= 1'b0;
      end
      else
      begin
         if (vec_low_write)
            vector_low_base <= io_wdata[7:5];
         if (ctrl_write)
         begin
            {level2_input_enable, level1_input_enable, level0_input_enable}
               <= io_wdata[2:0];
            if (!io_wdata[`CTRL_FLAG_BIT])
               fault_flag <= 1'b0;
         end
         // set wins over a clear in the same cycle
         if (trap_event)
         begin
            fault_flag <= 1'b1;
            fault_byte_position <= undefined_in_third_byte;
         end
         // falling edge held until taken
         nmi_prev <= nmi_n;
         if (nmi_prev && !nmi_n)
            nmi_latched <= 1'b1;
         else if (ack_take && service_kind == kind_nmi)
            nmi_latched <= 1'b0;
         // flag updates; trap and maskable return leave them alone
         if (ack_take && service_kind == kind_nmi)
         begin
            saved_global_enable <= primary_global_enable;
            primary_global_enable <= 1'b0;
         end
         else if (ack_take && (service_kind == kind_level0 ||
                  service_kind == kind_vector))
         begin
            primary_global_enable <= 1'b0;
            saved_global_enable <= 1'b0;
         end
         else if (disable_interrupts_instr)
         begin
            primary_global_enable <= 1'b0;
            saved_global_enable <= 1'b0;
         end
         else if (enable_interrupts_instr)
         begin
            primary_global_enable <= 1'b1;
            saved_global_enable <= 1'b1;
         end
         else if (nonmaskable_return)
            primary_global_enable <= saved_global_enable;
         else if (maskable_return)
         begin
            primary_global_enable <= primary_global_enable;
            saved_global_enable <= saved_global_enable;
         end
      end
   end

   // ==========================================================
   // arbitration
   // ==========================================================
   assign maskable_ok = primary_global_enable;
   // level 1, level 2 then eight internal sources
   assign pending = {internal_request,
                     ~level2_request_n & level2_input_enable,
                     ~level1_request_n & level1_input_enable}
                    & {10{maskable_ok}};

   int_priority_pick i_int_priority_pick
   (
      .pending(pending),
      .index(pick_index),
      .found(pick_found)
   );

   assign level0_ok = maskable_ok & level0_input_enable & ~level0_request_n;
   assign service_request = trap_pending | nmi_latched | level0_ok |
      pick_found;
   assign vector_from_table = (service_kind == kind_vector) |
      (service_kind == kind_level0 && level0_mode == 2'h2);
   // the fault state must run straight into the stack push
   assign cycle_insert_block = fault_insert_state;
   assign primary_global_enable_out = primary_global_enable;
   assign saved_global_enable_out = saved_global_enable;

   // ==========================================================
   // answers: kind and restart or table address
   // ==========================================================
   // fixed priority: trap, nmi, level 0, then the vectored sources
   always @*
   begin
      next_service_kind = 4'h0;
      next_service_address = service_address;
      next_vector_from_bus = 1'b0;
      if (trap_pending)
      begin
         next_service_kind = kind_trap;
         next_service_address = `TRAP_RESTART;
      end
      else if (nmi_latched)
      begin
         next_service_kind = kind_nmi;
         next_service_address = `NMI_RESTART;
      end
      else if (level0_ok)
      begin
         next_service_kind = kind_level0;
         case (level0_mode)
            2'h1:
            begin
               next_service_address = `MODE1_RESTART;
            end
            2'h2:
            begin
               next_service_address = {vector_high, 8'h00};
               next_vector_from_bus = 1'b1;
            end
            default:
            begin
               // mode 0: the instruction itself comes from the bus
               next_service_address = 16'h0000;
               next_vector_from_bus = 1'b1;
            end
         endcase
      end
      else if (pick_found)
      begin
         next_service_kind = kind_vector;
         next_service_address = {vector_high, vector_low_base,
                                 fixed_code(pick_index)};
      end
   end

   // live bits read back; other addresses read zero
   always @*
   begin
      next_io_rdata = 8'h00;
      if (vec_low_read)
         next_io_rdata = {vector_low_base, 5'h00};
      else if (ctrl_read)
         next_io_rdata = {fault_flag, fault_byte_position, 3'h0,
            level2_input_enable, level1_input_enable,
            level0_input_enable};
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         service_kind <= 4'h0;
         service_address <= 16'h0000;
         vector_from_bus <= 1'b0;
         io_rdata <= 8'h00;
         parity_flag_value <= 1'b0;
         parity_flag_load <= 1'b0;
      end
      else
      begin
         service_kind <= next_service_kind;
         service_address <= next_service_address;
         vector_from_bus <= next_vector_from_bus;
         io_rdata <= next_io_rdata;
         parity_flag_load <= load_a_from_i_or_r;
         parity_flag_value <= primary_global_enable;
      end
   end
endmodule // interrupt_trap_control
`default_nettype wire

// [tb/itc_monitor.sv]
// concurrent checks on the interrupt and trap control ports
`timescale 1ns/10ps
`default_nettype none
module itc_monitor
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable_interrupts_instr,
   input wire logic disable_interrupts_instr,
   input wire logic nonmaskable_return,
   input wire logic load_a_from_i_or_r,
   input wire logic undefined_fetch,
   input wire logic level0_ack_fetch,
   input wire logic [1:0] level0_mode,
   input wire logic ack_take,
   input wire logic fault_insert_state,
   input wire logic [3:0] service_kind,
   input wire logic [15:0] service_address,
   input wire logic parity_flag_value,
   input wire logic parity_flag_load,
   input wire logic cycle_insert_block,
   input wire logic primary_global_enable_out,
   input wire logic saved_global_enable_out
);
   // ====
   // flag and trap checks
   wire pge = primary_global_enable_out;
   wire sge = saved_global_enable_out;
   wire ev = enable_interrupts_instr | disable_interrupts_instr | ack_take;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_di_clears: assert property (
      disable_interrupts_instr |=> !pge && !sge) else $error("di flags");
   a_ei_sets: assert property (
      enable_interrupts_instr && !disable_interrupts_instr && !ack_take
      |=> pge && sge) else $error("ei flags");
   a_nonmaskable_return_restores: assert property (
      nonmaskable_return && !ev |=> pge == $past(sge) && $stable(sge))
      else $error("nonmaskable_return flags");
   a_nmi_saves: assert property (
      ack_take && service_kind == 4'h2 |=> !pge && sge == $past(pge))
      else $error("nmi accept flags");
   a_mask_clears: assert property (
      ack_take && service_kind[3:2] != 2'b00 |=> !pge && !sge)
      else $error("maskable accept flags");
   a_trap_vector: assert property (
      undefined_fetch && (!level0_ack_fetch || level0_mode == 2'h0)
      |=> ##1 service_kind == 4'h1 && service_address == 16'h0000)
      else $error("trap service");
   a_parity_copy: assert property (
      load_a_from_i_or_r
      |=> parity_flag_load && parity_flag_value == $past(pge))
      else $error("parity copy");
   a_insert_block: assert property (
      cycle_insert_block == fault_insert_state) else $error("insert block");
   cover property (ack_take && service_kind == 4'h2);
   cover property (ack_take && service_kind == 4'h8);
   cover property (undefined_fetch);
   cover property (ack_take && service_kind == 4'h4);
endmodule // itc_monitor
bind interrupt_trap_control itc_monitor i_itc_monitor (.*);
`default_nettype wire

// [tb/seq_partner.sv]
// sequencer model that accepts offered services after a wait
`timescale 1ns/10ps
`default_nettype none
module seq_partner #(parameter int WAIT = 1)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ack_en,
   input wire logic service_request,
   input wire logic [3:0] service_kind,
   output logic ack_take
);
   int cnt;
   // one pulse per offer; a held ack would swallow the next request
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         ack_take <= 1'b0;
         cnt <= 0;
      end
      else
      begin
         ack_take <= 1'b0;
         cnt <= 0;
         if (ack_en && service_request && service_kind !== 4'h0 && !ack_take)
         begin
            cnt <= cnt + 1;
            if (cnt >= WAIT)
               ack_take <= 1'b1;
         end
      end
endmodule // seq_partner
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the interrupt and trap control block
`timescale 1ns/10ps
`default_nettype none
`include "int_ctrl_regs.vh"
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk = 0, reset_n = 0, io_write = 0, io_read = 0, ack_en = 0;
   logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, vector_high = 8'h00;
   logic [7:0] internal_request = 8'h00, io_rdata;
   logic [1:0] level0_mode = 2'h0;
   logic [5:0] ev = 6'h00;
   logic [3:0] req_n = 4'hF, service_kind;
   logic undefined_in_third_byte = 0, level0_ack_fetch = 0;
   logic fault_insert_state = 0, ack_take, service_request, vector_from_bus;
   logic enable_interrupts_instr, disable_interrupts_instr, maskable_return;
   logic nonmaskable_return, load_a_from_i_or_r, undefined_fetch, nmi_n;
   logic level0_request_n, level1_request_n, level2_request_n;
   logic vector_from_table, parity_flag_value, parity_flag_load;
   logic cycle_insert_block, primary_global_enable_out;
   logic saved_global_enable_out;
   logic [15:0] service_address;
   int mismatches = 0, tests_run = 0;
   assign {undefined_fetch, load_a_from_i_or_r, maskable_return} = ev[5:3];
   assign {nonmaskable_return, disable_interrupts_instr} = ev[2:1];
   assign enable_interrupts_instr = ev[0];
   assign {nmi_n, level2_request_n} = req_n[3:2];
   assign {level1_request_n, level0_request_n} = req_n[1:0];
   interrupt_trap_control i_interrupt_trap_control (.*);
   seq_partner i_seq_partner (.*);
   always #25 clk = ~clk;
   // ====
   // bus and event tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic io_wr(input logic [7:0] a, d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_write <= 1'b1;
      @(posedge clk);
      io_write <= 1'b0;
   endtask
   task automatic io_rd(input logic [7:0] a, e, m = 8'hFF);
      @(posedge clk);
      io_addr <= a;
      io_read <= 1'b1;
      @(posedge clk);
      io_read <= 1'b0;
      #1;
      `CHECK("io_rdata", e, io_rdata & m)
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      #1;
   endtask
   task automatic ack_all(input logic [3:0] r);
      @(posedge clk);
      ack_en <= 1'b1;
      repeat (4) @(posedge clk);
      ack_en <= 1'b0;
      req_n <= r;
      tick(1);
   endtask
   // ====
   // scenarios
   task automatic t_regs;
      io_rd(`VEC_LOW_ADDR, 8'h00);
      io_rd(`CTRL_ADDR, 8'h01);
      io_wr(`VEC_LOW_ADDR, 8'hFF);
      io_rd(`VEC_LOW_ADDR, 8'hE0);
      io_rd(8'h35, 8'h00);
      io_wr(`CTRL_ADDR, 8'hFE);
      io_rd(`CTRL_ADDR, 8'h06);
   endtask
   task automatic t_trap;
      @(posedge clk);
      undefined_in_third_byte <= 1'b1;
      level0_ack_fetch <= 1'b1;
      fault_insert_state <= 1'b1;
      pulse(5);
      tick(1);
      `CHECK("kind", 4'h1, service_kind)
      `CHECK("addr", 16'h0000, service_address)
      `CHECK("block", 1'b1, cycle_insert_block)
      io_rd(`CTRL_ADDR, 8'hC6);
      io_wr(`CTRL_ADDR, 8'h86);
      io_rd(`CTRL_ADDR, 8'hC6);
      io_wr(`CTRL_ADDR, 8'h06);
      io_rd(`CTRL_ADDR, 8'h06, 8'hBF);
      fault_insert_state <= 1'b0;
      level0_ack_fetch <= 1'b0;
      ack_all(4'hF);
      `CHECK("req", 1'b0, service_request)
   endtask
   task automatic t_vect;
      io_wr(`VEC_LOW_ADDR, 8'hA0);
      io_wr(`CTRL_ADDR, 8'h04);
      @(posedge clk);
      vector_high <= 8'h12;
      req_n <= 4'b1001;
      tick(3);
      `CHECK("masked", 1'b0, service_request)
      pulse(0);
      tick(2);
      `CHECK("kind", 4'h8, service_kind)
      `CHECK("addr", 16'h12A2, service_address)
      `CHECK("table", 1'b1, vector_from_table)
      ack_all(4'hF);
      `CHECK("pge", 1'b0, primary_global_enable_out)
      `CHECK("sge", 1'b0, saved_global_enable_out)
   endtask
   task automatic t_nmi;
      pulse(0);
      @(posedge clk);
      req_n <= 4'b0111;
      tick(3);
      `CHECK("kind", 4'h2, service_kind)
      `CHECK("addr", 16'h0066, service_address)
      ack_all(4'b0111);
      `CHECK("sge", 1'b1, saved_global_enable_out)
      `CHECK("req", 1'b0, service_request)
      pulse(2);
      `CHECK("pge", 1'b1, primary_global_enable_out)
      `CHECK("sge", 1'b1, saved_global_enable_out)
      pulse(4);
      `CHECK("load", 1'b1, parity_flag_load)
      `CHECK("parity", 1'b1, parity_flag_value)
      pulse(1);
      `CHECK("pge", 1'b0, primary_global_enable_out)
      `CHECK("sge", 1'b0, saved_global_enable_out)
   endtask
   task automatic t_mode1(input logic [1:0] md, input logic [15:0] ea);
      io_wr(`CTRL_ADDR, 8'h01);
      @(posedge clk);
      level0_mode <= md;
      req_n <= 4'b1110;
      pulse(0);
      tick(2);
      `CHECK("kind", 4'h4, service_kind)
      `CHECK("addr", ea, service_address)
      `CHECK("bus", md != 2'h1, vector_from_bus)
      `CHECK("table", md == 2'h2, vector_from_table)
      ack_all(4'hF);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      t_regs;
      t_trap;
      t_vect;
      t_nmi;
      t_mode1(2'h1, 16'h0038);
      t_mode1(2'h2, 16'h1200);
      t_mode1(2'h0, 16'h0000);
      finish_test;
   end
   // run needs about 6.2 us; limit leaves ample slack
   initial
   begin
      #200000;
      mismatches++;
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
